// [inc/psd_pkg.sv]
// Package of constants and types for the pin state detection counter.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package psd_pkg;
    // Register offsets on the plain register port (word offsets).
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_INCR = 4'h1;
    localparam logic [3:0] ADDR_ACCUM = 4'h2;
    localparam logic [3:0] ADDR_PINS = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;

    // Control register field positions.
    localparam int CTRL_MODE_LSB = 26;
    localparam int CTRL_PLL_DIV_LSB = 23;
    localparam int CTRL_FBPIN_LSB = 9;
    localparam int CTRL_SENSEPIN_LSB = 0;
    localparam logic [31:0] CTRL_WRITE_MASK = 32'h7F80_3E1F;

    // Pin control register field positions.
    localparam int PINS_DIR_BIT = 0;
    localparam int PINS_OUT_BIT = 1;

    // Reset values.
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // Mode codes.
    localparam logic [4:0] MODE_POS = 5'h08;
    localparam logic [4:0] MODE_POS_FB = 5'h09;
    localparam logic [4:0] MODE_RISE = 5'h0A;
    localparam logic [4:0] MODE_RISE_FB = 5'h0B;
    localparam logic [4:0] MODE_NEG = 5'h0C;
    localparam logic [4:0] MODE_NEG_FB = 5'h0D;
    localparam logic [4:0] MODE_FALL = 5'h0E;
    localparam logic [4:0] MODE_FALL_FB = 5'h0F;
    localparam logic [4:0] MODE_LOGIC_A = 5'h1A;
    localparam logic [4:0] MODE_LOGIC_NOT_A = 5'h15;

    // Sense pin samples travelling together.
    typedef struct packed {
        logic once;
        logic twice;
    } psd_sample_t;

    // Register bus request.
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } psd_bus_t;
endpackage

// [design/psd_sampler.sv]
// Two-stage sampler of the selected sense pin.
`timescale 1ns/1ps
module psd_sampler (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [31:0] pinIn,
    input wire logic [4:0] pinSel,
    output psd_pkg::psd_sample_t sample
);
    logic once_q;
    logic twice_q;

    //------------------------------------------------------------------------------
    // Sample stages
    //------------------------------------------------------------------------------
    // once-registered sample
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            once_q <= 1'b0;
            twice_q <= 1'b0;
        end else begin
            once_q <= pinIn[pinSel];
            twice_q <= once_q;
        end
    end

    // Both stages go out together so edge logic sees a matched pair.
    assign sample.once = once_q;
    assign sample.twice = twice_q;
endmodule

// [design/psd_condition.sv]
// Accumulate-condition decoder for pin state and logic modes.
`timescale 1ns/1ps
module psd_condition (
    input wire logic [4:0] mode,
    input psd_pkg::psd_sample_t sample,
    output logic accumulate,
    output logic feedbackEn
);
    // Decode; the PLL divider is not an input here so it cannot matter.
    always_comb begin
        accumulate = 1'b0;
        case (mode)
            psd_pkg::MODE_POS, psd_pkg::MODE_POS_FB: begin
                accumulate = sample.once;
            end
            psd_pkg::MODE_NEG, psd_pkg::MODE_NEG_FB: begin
                accumulate = ~sample.once;
            end
            psd_pkg::MODE_RISE, psd_pkg::MODE_RISE_FB: begin
                accumulate = sample.once & ~sample.twice;
            end
            psd_pkg::MODE_FALL, psd_pkg::MODE_FALL_FB: begin
                accumulate = ~sample.once & sample.twice;
            end
            psd_pkg::MODE_LOGIC_A: begin
                accumulate = sample.once;
            end
            psd_pkg::MODE_LOGIC_NOT_A: begin
                accumulate = ~sample.once;
            end
            default: begin
                accumulate = 1'b0;
            end
        endcase
    end

    assign feedbackEn = (mode[4:3] == 2'b01) & mode[0];
endmodule

// [design/psd_counter.sv]
// Top level of the pin state detection accumulator counter.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module psd_counter (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic [31:0] pinIn,
    output logic [31:0] pinOut,
    output logic [31:0] pinOe_n
);
    psd_pkg::psd_bus_t bus;
    logic [31:0] ctrl_q;
    logic [31:0] incr_q;
    logic [31:0] accum_q;
    logic [31:0] accum_d;
    logic [1:0] pins_q;
    logic [31:0] regRdata_q;
    logic [31:0] pinOut_q;
    logic [31:0] pinOe_n_q;
    logic [4:0] mode;
    logic [4:0] sensePin;
    logic [4:0] feedbackPin;
    logic accumulate;
    logic feedbackEn;
    logic feedbackDrive;
    logic feedbackLevel;
    psd_pkg::psd_sample_t sample;
    logic accumWrite;

    assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
    // Software write to the accumulator; it overrides any add in the same cycle, so the
    // checks below leave such cycles to the write check.
    assign accumWrite = bus.wr && bus.addr == psd_pkg::ADDR_ACCUM;

    //------------------------------------------------------------------------------
    // Field extraction
    //------------------------------------------------------------------------------
    // divider field unused
    assign mode = ctrl_q[psd_pkg::CTRL_MODE_LSB +: 5];
    assign sensePin = ctrl_q[psd_pkg::CTRL_SENSEPIN_LSB +: 5];
    assign feedbackPin = ctrl_q[psd_pkg::CTRL_FBPIN_LSB +: 5];

    //------------------------------------------------------------------------------
    // Submodules
    //------------------------------------------------------------------------------
    psd_sampler u_sampler (
        .sys_clk(sys_clk),
        .reset(reset),
        .pinIn(pinIn),
        .pinSel(sensePin),
        .sample(sample)
    );

    psd_condition u_cond (
        .mode(mode),
        .sample(sample),
        .accumulate(accumulate),
        .feedbackEn(feedbackEn)
    );

    //------------------------------------------------------------------------------
    // Configuration registers
    //------------------------------------------------------------------------------
    // mode active from next clock
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= psd_pkg::RESET_WORD;
        end else if (bus.wr && bus.addr == psd_pkg::ADDR_CTRL) begin
            ctrl_q <= bus.wdata & psd_pkg::CTRL_WRITE_MASK; // Reserved bits stay zero.
        end
    end

    // Increment register.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            incr_q <= psd_pkg::RESET_WORD;
        end else if (bus.wr && bus.addr == psd_pkg::ADDR_INCR) begin
            incr_q <= bus.wdata;
        end
    end

    // Direction and output bits of the feedback pin.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pins_q <= 2'h0;
        end else if (bus.wr && bus.addr == psd_pkg::ADDR_PINS) begin
            pins_q <= bus.wdata[1:0];
        end
    end

    //------------------------------------------------------------------------------
    // Accumulator
    //------------------------------------------------------------------------------
    // add increment when true
    assign accum_d = accumulate ? accum_q + incr_q : accum_q;

    // wrap and software overwrite
    // A software write wins over an add in the same cycle, as software asked for that value.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            accum_q <= psd_pkg::RESET_WORD;
        end else if (bus.wr && bus.addr == psd_pkg::ADDR_ACCUM) begin
            accum_q <= bus.wdata;
        end else begin
            accum_q <= accum_d;
        end
    end

    //------------------------------------------------------------------------------
    // Read port
    //------------------------------------------------------------------------------
    // Read data stand one cycle after the strobe; unmapped addresses read zero.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            regRdata_q <= psd_pkg::RESET_WORD;
        end else if (bus.rd) begin
            case (bus.addr)
                psd_pkg::ADDR_CTRL: begin
                    regRdata_q <= ctrl_q;
                end
                psd_pkg::ADDR_INCR: begin
                    regRdata_q <= incr_q;
                end
                psd_pkg::ADDR_ACCUM: begin
                    regRdata_q <= accum_q;
                end
                psd_pkg::ADDR_PINS: begin
                    regRdata_q <= {30'h0, pins_q};
                end
                psd_pkg::ADDR_STATUS: begin
                    regRdata_q <= {28'h0, feedbackEn, accumulate, sample.twice, sample.once};
                end
                default: begin
                    regRdata_q <= psd_pkg::RESET_WORD;
                end
            endcase
        end else begin
            regRdata_q <= psd_pkg::RESET_WORD;
        end
    end
    assign regRdata = regRdata_q;

    //------------------------------------------------------------------------------
    // Pin drive
    //------------------------------------------------------------------------------
    // inverse of the sensed level
    assign feedbackLevel = ~pinIn[sensePin];
    // gate by direction, OR with output bit
    assign feedbackDrive = pins_q[psd_pkg::PINS_DIR_BIT]
        & ((feedbackEn & feedbackLevel) | pins_q[psd_pkg::PINS_OUT_BIT]);

    // Outputs are registered, so the feedback lags the pin by one clock; the RC loop
    // tolerates that and it keeps every output on a flip-flop.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pinOut_q <= 32'h0000_0000;
            pinOe_n_q <= 32'hFFFF_FFFF;
        end else begin
            pinOut_q <= 32'h0000_0000;
            pinOe_n_q <= 32'hFFFF_FFFF;
            pinOut_q[feedbackPin] <= feedbackDrive;
            pinOe_n_q[feedbackPin] <= ~pins_q[psd_pkg::PINS_DIR_BIT];
        end
    end
    assign pinOut = pinOut_q;
    assign pinOe_n = pinOe_n_q;

    //------------------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------------------
    a_level_high_add: assert property (@(posedge sys_clk) disable iff (reset)
        (mode == psd_pkg::MODE_POS && sample.once && !(bus.wr && bus.addr == psd_pkg::ADDR_ACCUM))
        |=> accum_q == $past(accum_q) + $past(incr_q))
        else $error("High level did not add the increment.");

    a_level_low_hold: assert property (@(posedge sys_clk) disable iff (reset)
        (mode == psd_pkg::MODE_NEG && sample.once && !bus.wr) |=> accum_q == $past(accum_q))
        else $error("Low level mode added while the pin was high.");

    a_rise_once: assert property (@(posedge sys_clk) disable iff (reset)
        (mode[4:1] == 4'h5 && !accumWrite) |=> accum_q == $past(accum_q)
            + (($past(sample.once) && !$past(sample.twice)) ? $past(incr_q) : 32'h0))
        else $error("Rising edge did not add exactly once.");

    a_fall_once: assert property (@(posedge sys_clk) disable iff (reset)
        (mode[4:1] == 4'h7 && !accumWrite) |=> accum_q == $past(accum_q)
            + ((!$past(sample.once) && $past(sample.twice)) ? $past(incr_q) : 32'h0))
        else $error("Falling edge did not add exactly once.");

    a_sample_chain: assert property (@(posedge sys_clk) disable iff (reset)
        ##1 sample.twice == $past(sample.once))
        else $error("Second sample stage does not follow the first.");

    // The stages are held through the reset edge while the pin is not, so skip that cycle.
    a_level_sample: assert property (@(posedge sys_clk) disable iff (reset)
        ($stable(sensePin) && !$past(reset)) |-> sample.once == $past(pinIn[sensePin]))
        else $error("Level sample is not the previous pin value.");

    a_even_no_fb: assert property (@(posedge sys_clk) disable iff (reset)
        (mode[4:3] == 2'b01 && !mode[0] && !pins_q[psd_pkg::PINS_OUT_BIT]
         && $stable(pins_q)) |=> pinOut_q[$past(feedbackPin)] == 1'b0)
        else $error("Even mode drove the feedback pin.");

    a_dir_gate: assert property (@(posedge sys_clk) disable iff (reset)
        !pins_q[psd_pkg::PINS_DIR_BIT] |=> pinOe_n_q == 32'hFFFF_FFFF && pinOut_q == 32'h0)
        else $error("Feedback pin driven with direction bit clear.");

    a_accum_write: assert property (@(posedge sys_clk) disable iff (reset)
        (bus.wr && bus.addr == psd_pkg::ADDR_ACCUM) |=> accum_q == $past(bus.wdata))
        else $error("Accumulator write not taken on the next clock.");

    a_mode_at_once: assert property (@(posedge sys_clk) disable iff (reset)
        (bus.wr && bus.addr == psd_pkg::ADDR_CTRL) |=> mode == $past(bus.wdata[30:26]))
        else $error("Mode did not take effect on the next clock.");

    //------------------------------------------------------------------------------
    // Assertions on the accumulate decode
    //------------------------------------------------------------------------------
    // These restate the mode table rather than the decoder, so a slip in either one
    // shows up as a disagreement instead of being copied twice.
    a_mode_table: assert property (@(posedge sys_clk) disable iff (reset)
        (mode[4:3] == 2'b01) |-> accumulate == (mode[1]
            ? (mode[2] ? (!sample.once && sample.twice) : (sample.once && !sample.twice))
            : (mode[2] ? !sample.once : sample.once)))
        else $error("Pin state mode decoded the wrong condition.");

    a_other_idle: assert property (@(posedge sys_clk) disable iff (reset)
        (mode[4:3] != 2'b01 && mode != psd_pkg::MODE_LOGIC_A
         && mode != psd_pkg::MODE_LOGIC_NOT_A) |-> !accumulate)
        else $error("A mode outside the detection set accumulated.");

    a_logic_high: assert property (@(posedge sys_clk) disable iff (reset)
        (mode == psd_pkg::MODE_LOGIC_A) |-> accumulate == sample.once)
        else $error("Logic high mode differs from the high level mode.");

    a_logic_low: assert property (@(posedge sys_clk) disable iff (reset)
        (mode == psd_pkg::MODE_LOGIC_NOT_A) |-> accumulate == !sample.once)
        else $error("Logic low mode differs from the low level mode.");

    //------------------------------------------------------------------------------
    // Assertions on the accumulator, the increment register and the read port
    //------------------------------------------------------------------------------
    // The write exclusion matches the write-wins choice in the accumulator process.
    a_add_true: assert property (@(posedge sys_clk) disable iff (reset)
        (accumulate && !accumWrite) |=> accum_q == $past(accum_q) + $past(incr_q))
        else $error("True condition did not add the increment.");

    a_hold_false: assert property (@(posedge sys_clk) disable iff (reset)
        (!accumulate && !accumWrite) |=> accum_q == $past(accum_q))
        else $error("Accumulator moved while the condition was false.");

    a_pos_no_add: assert property (@(posedge sys_clk) disable iff (reset)
        (mode == psd_pkg::MODE_POS_FB && !sample.once && !accumWrite)
        |=> accum_q == $past(accum_q))
        else $error("High level mode added while the pin was low.");

    a_neg_add: assert property (@(posedge sys_clk) disable iff (reset)
        (mode == psd_pkg::MODE_NEG_FB && !sample.once && !accumWrite)
        |=> accum_q == $past(accum_q) + $past(incr_q))
        else $error("Low level mode did not add while the pin was low.");

    a_incr_write: assert property (@(posedge sys_clk) disable iff (reset)
        (bus.wr && bus.addr == psd_pkg::ADDR_INCR) |=> incr_q == $past(bus.wdata))
        else $error("Increment write not taken on the next clock.");

    a_accum_read: assert property (@(posedge sys_clk) disable iff (reset)
        (bus.rd && bus.addr == psd_pkg::ADDR_ACCUM) |=> regRdata_q == $past(accum_q))
        else $error("Accumulator read returned a stale value.");

    // Read data stand for one cycle only, so a master that samples late sees zero.
    a_read_idle: assert property (@(posedge sys_clk) disable iff (reset)
        !bus.rd |=> regRdata_q == 32'h0)
        else $error("Read data stood outside the answer cycle.");

    //------------------------------------------------------------------------------
    // Assertions on the pins
    //------------------------------------------------------------------------------
    // The feedback is registered, so it answers the pin level of the previous edge.
    a_fb_invert: assert property (@(posedge sys_clk) disable iff (reset)
        (mode[4:3] == 2'b01 && mode[0] && pins_q == 2'b01)
        |=> pinOut_q[$past(feedbackPin)] == !$past(pinIn[sensePin])
            && !pinOe_n_q[$past(feedbackPin)])
        else $error("Odd mode did not drive the inverse of the sense pin.");

    a_fb_outbit: assert property (@(posedge sys_clk) disable iff (reset)
        (pins_q == 2'b11) |=> pinOut_q[$past(feedbackPin)] && !pinOe_n_q[$past(feedbackPin)])
        else $error("Output bit did not force the feedback pin high.");

    // Only the feedback pin may ever be enabled; a stray enable would fight the source.
    a_one_enable: assert property (@(posedge sys_clk) disable iff (reset)
        1'b1 |=> (pinOe_n_q | (32'h1 << $past(feedbackPin))) == 32'hFFFF_FFFF)
        else $error("A pin other than the feedback pin was enabled.");

    a_one_level: assert property (@(posedge sys_clk) disable iff (reset)
        1'b1 |=> (pinOut_q & ~(32'h1 << $past(feedbackPin))) == 32'h0)
        else $error("A pin other than the feedback pin was driven high.");
endmodule

// [testbench/psd_pin_partner.sv]
// Behavioural pin source and sigma-delta network on the far side of the counter.
`timescale 1ns/1ps
// ----------------------------------------
// Pin source model
// ----------------------------------------
module psd_pin_partner #(
    parameter int VIN = 4,
    parameter int STEP = 8
) (
    input wire logic sys_clk,
    input wire logic [31:0] pinOut,
    input wire logic [31:0] pinOe_n,
    input wire logic [4:0] senseIdx,
    input wire logic [4:0] fbIdx,
    input wire logic srcLevel,
    input wire logic loopOn,
    output logic [31:0] pinIn
);
    logic [31:0] junk = 32'h0;
    logic fbLast = 1'b0;
    logic fbWire;
    int volt = 0;
    // A released feedback line shows the inverse of its last level, so stale data cannot pass.
    assign fbWire = pinOe_n[fbIdx] ? ~fbLast : pinOut[fbIdx];
    // The capacitor charges from the input and is pulled back by the feedback pin.
    always @(posedge sys_clk) begin
        junk <= junk + 32'h9E37_79B9;
        fbLast <= fbWire;
        volt <= loopOn ? volt + VIN + (fbWire ? STEP : -STEP) : 0;
    end
    // Unused pins follow a running count (pin 0 toggles every cycle) so a wrong pin select shows up.
    always_comb begin
        pinIn = junk;
        pinIn[fbIdx] = fbWire;
        pinIn[senseIdx] = loopOn ? (volt > 0) : srcLevel;
    end
endmodule

// [testbench/pin_state_detect_counter_tb_top.sv]
// Self-checking bench for the pin state detection counter.
`timescale 1ns/1ps
module pin_state_detect_counter_tb_top;
    localparam logic [4:0] SENSE = 5'h07;
    localparam logic [4:0] FB = 5'h02;
    localparam logic [31:0] BASE = (32'(FB) << psd_pkg::CTRL_FBPIN_LSB) | 32'(SENSE);
    localparam logic [31:0] PRE = 32'hFFFF_FFF0;
    localparam logic [31:0] INC = 32'h0000_0003;
    localparam logic [15:0] PAT = 16'hB2C5;
    logic sys_clk, reset, regWr, regRd, srcLevel, loopOn;
    logic [3:0] regAddr;
    logic [31:0] regWdata, regRdata, pinIn, pinOut, pinOe_n, rdVal, first;
    logic [4:0] modes [10] = '{5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F,
                               5'h1A, 5'h15};
    int errors = 0;
    int num_checks = 0;

    psd_counter i_dut (.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n));
    psd_pin_partner i_partner (.sys_clk(sys_clk), .pinOut(pinOut), .pinOe_n(pinOe_n),
        .senseIdx(SENSE), .fbIdx(FB), .srcLevel(srcLevel), .loopOn(loopOn), .pinIn(pinIn));

    // ----------------------------------------
    // Clock, watchdog and bench tasks
    // ----------------------------------------
    // Free-running system clock.
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // The whole run needs under two thousand cycles; ten times that means a hang.
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        print_verdict();
    end
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd(logic [3:0] a);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        rdVal = regRdata;
    endtask
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Counts accumulate events over idle, pattern, idle; idle never accumulates.
    function automatic int hits(logic [4:0] m, logic idle);
        logic prev;
        logic b;
        int n;
        prev = idle;
        n = 0;
        for (int i = 0; i <= 16; i++) begin
            b = (i < 16) ? PAT[i] : idle;
            if (m == 5'h08 || m == 5'h09 || m == 5'h1A) n += int'(b);
            else if (m == 5'h0C || m == 5'h0D || m == 5'h15) n += int'(!b);
            else if (m == 5'h0A || m == 5'h0B) n += int'(b & !prev);
            else n += int'(!b & prev);
            prev = b;
        end
        return n;
    endfunction
    task automatic run_mode(logic [4:0] m);
        logic idle;
        logic odd;
        logic [31:0] cfg;
        idle = m[2] & ~m[1];
        odd = (m[4:3] == 2'b01) & m[0];
        cfg = BASE | (32'({3{odd}}) << psd_pkg::CTRL_PLL_DIV_LSB);
        wr(psd_pkg::ADDR_CTRL, cfg);
        srcLevel <= idle;
        wr(psd_pkg::ADDR_INCR, INC);
        wr(psd_pkg::ADDR_ACCUM, PRE);
        wr(psd_pkg::ADDR_PINS, 32'h0000_0001);
        wr(psd_pkg::ADDR_CTRL, cfg | (32'(m) << psd_pkg::CTRL_MODE_LSB));
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            srcLevel <= PAT[i];
        end
        @(posedge sys_clk);
        srcLevel <= idle;
        repeat (4) @(posedge sys_clk);
        rd(psd_pkg::ADDR_ACCUM);
        chk(rdVal, PRE + INC * 32'(hits(m, idle)));
        rd(psd_pkg::ADDR_STATUS);
        chk(rdVal, {28'h0, odd, 1'b0, idle, idle});
        chk(pinOut, {31'h0, odd & ~idle} << FB);
        chk(pinOe_n, ~(32'h0000_0001 << FB));
        rd(psd_pkg::ADDR_CTRL);
        chk(rdVal, cfg | (32'(m) << psd_pkg::CTRL_MODE_LSB));
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    // Reset, every mode, feedback gating, then a sigma-delta conversion.
    initial begin
        reset = 1'b1;
        regAddr = 4'h0;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        srcLevel = 1'b0;
        loopOn = 1'b0;
        repeat (16) @(posedge sys_clk);
        chk(pinOe_n, 32'hFFFF_FFFF);
        chk(regRdata, 32'h0);
        reset <= 1'b0;
        // Sense pin 0 toggles every cycle after reset, so the two status samples differ.
        for (int a = 0; a < 6; a++) begin
            rd(4'(a));
            chk(rdVal, (a == 4) ? {30'h0, rdVal[1], ~rdVal[1]} : 32'h0);
        end
        wr(psd_pkg::ADDR_CTRL, 32'hFFFF_FFFF);
        rd(psd_pkg::ADDR_CTRL);
        chk(rdVal, 32'h7F80_3E1F);
        foreach (modes[k]) run_mode(modes[k]);
        wr(psd_pkg::ADDR_CTRL, BASE | (32'h08 << psd_pkg::CTRL_MODE_LSB));
        for (int p = 0; p < 4; p++) begin
            wr(psd_pkg::ADDR_PINS, 32'(p));
            repeat (2) @(posedge sys_clk);
            #1;
            chk(pinOut, {31'h0, p == 3} << FB);
            chk(pinOe_n, ~({31'h0, p[0]} << FB));
        end
        // unit increment, reads 31 cycles apart
        wr(psd_pkg::ADDR_CTRL, BASE);
        loopOn <= 1'b1;
        wr(psd_pkg::ADDR_INCR, 32'h0000_0001);
        wr(psd_pkg::ADDR_PINS, 32'h0000_0001);
        wr(psd_pkg::ADDR_CTRL, BASE | (32'h09 << psd_pkg::CTRL_MODE_LSB));
        repeat (200) @(posedge sys_clk);
        rd(psd_pkg::ADDR_ACCUM);
        first = rdVal;
        repeat (29) @(posedge sys_clk);
        rd(psd_pkg::ADDR_ACCUM);
        chk({31'h0, (rdVal - first) inside {[32'd18:32'd28]}}, 32'h1);
        print_verdict();
    end
endmodule
